// ==== core/btrw_top.sv ====
// Bus timeout, system reset, watchdog, RTC ticks and front-panel LED
`include "btrw_defines.svh"
// Overview of operation
// - Bus error drives transfer error low
// - Low stage is 4-bit Gray counter
// - 4-bit high stage, error at 153
// - Size acknowledge ends cycle without error
// - Watchdog logic also makes reset
// - Unserviced watchdog issues reset pulse
// - LED dark while system reset low
// - 128 Hz periodic interrupt pulse
// - 32 kHz refresh clock from base
// - Panel LED follows register LSB
// - LED write-only, read returns option data
// - Each serial access moves one MSB bit
module btrw_top
    import btrw_pkg::*;
#(
    parameter int WD_CYCLES = `BTRW_WD_CYC,
    parameter int TICK_CYCLES = `BTRW_TICK_CYC
)
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic TRANSFER_START_N_I,
    input wire logic TRANSFER_ACK_N_I,
    input wire logic [1:0] SIZE_ACK_N_I,
    input wire logic WATCHDOG_SENSE_I,
    input wire logic LED_SEL_N_I,
    input wire logic SERIAL_WR_N_I,
    input wire logic SERIAL_RD_N_I,
    input wire logic SERIAL_WDATA_I,
    input wire logic OPTION_RDATA_I,
    output logic TRANSFER_ERROR_N_O,
    output logic SYS_RESET_N_O,
    output logic RESET_LED_O,
    output logic PANEL_LED_O,
    output logic SERIAL_SHIFT_CLOCK_N_O,
    output logic SERIAL_RDATA_O,
    output logic RTC_IRQ_N_O,
    output logic REFRESH_CLK_O
);
    btrw_sync_if pins ();
    assign pins.raw = {SERIAL_RD_N_I, SERIAL_WR_N_I, WATCHDOG_SENSE_I,
                       SIZE_ACK_N_I[1] & SIZE_ACK_N_I[0], TRANSFER_ACK_N_I};
    btrw_sync u_sync (.clk_i(CORE_CLK_I), .rst_i(RST_I), .pins(pins));

    wire logic ack_n = pins.clean[0];
    wire logic size_ack_n = pins.clean[1];
    wire logic wd_sense = pins.clean[2];
    wire logic ser_wr_n = pins.clean[3];
    wire logic ser_rd_n = pins.clean[4];

    function automatic logic [3:0] gray_inc(input logic [3:0] g);
        logic [3:0] b;
        b = {g[3], g[3] ^ g[2], g[3] ^ g[2] ^ g[1], g[3] ^ g[2] ^ g[1] ^ g[0]};
        b = b + 4'h1;
        return b ^ {1'b0, b[3:1]};
    endfunction : gray_inc

    function automatic logic [3:0] gray_to_bin(input logic [3:0] g);
        return {g[3], g[3] ^ g[2], g[3] ^ g[2] ^ g[1], g[3] ^ g[2] ^ g[1] ^ g[0]};
    endfunction : gray_to_bin

    // Bus cycle supervision
    btrw_cycle_t state_ff, nxt_state;
    logic [`BTRW_GRAY_W-1:0] gray_ff, nxt_gray;
    logic [`BTRW_HIGH_W-1:0] high_ff, nxt_high;
    logic tea_n_ff, nxt_tea_n;
    wire logic [`BTRW_STAGE_W-1:0] wait_count = {high_ff, gray_to_bin(gray_ff)};
    wire logic any_ack = ~ack_n | ~size_ack_n;
    wire logic limit_hit = (wait_count == `BTRW_WAIT_LIMIT - `BTRW_WAIT_ONE);
    wire logic gray_wrap = (gray_to_bin(gray_ff) == 4'hF);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_gray = gray_ff;
        nxt_high = high_ff;
        nxt_tea_n = 1'b1;
        unique case (state_ff)
            BTRW_IDLE:
            begin
                nxt_gray = '0;
                nxt_high = '0;
                if (!TRANSFER_START_N_I)
                    nxt_state = BTRW_COUNT;
            end
            BTRW_COUNT:
            begin
                if (any_ack)
                    nxt_state = BTRW_DONE;
                else if (limit_hit)
                begin
                    nxt_tea_n = 1'b0;
                    nxt_state = BTRW_DONE;
                end
                else
                begin
                    nxt_gray = gray_inc(gray_ff);
                    if (gray_wrap)
                        nxt_high = high_ff + 4'h1;
                end
            end
            BTRW_DONE:
            begin
                nxt_gray = '0;
                nxt_high = '0;
                // Wait for strobe release so one cycle is never counted twice
                if (TRANSFER_START_N_I)
                    nxt_state = BTRW_IDLE;
            end
            default: nxt_state = BTRW_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_ff <= BTRW_IDLE;
            gray_ff <= '0;
            high_ff <= '0;
            tea_n_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            gray_ff <= nxt_gray;
            high_ff <= nxt_high;
            tea_n_ff <= nxt_tea_n;
        end
    end
    assign TRANSFER_ERROR_N_O = tea_n_ff;

    // Watchdog: any sense edge restarts the interval
    logic wd_last_ff;
    logic [`BTRW_CNT_W-1:0] wd_cnt_ff;
    logic [`BTRW_CNT_W-1:0] rst_cnt_ff;
    wire logic wd_edge = wd_sense ^ wd_last_ff;
    wire logic wd_expire = (wd_cnt_ff == WD_CYCLES - 1);
    wire logic rst_active = (rst_cnt_ff != '0);

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wd_last_ff <= 1'b1;
            wd_cnt_ff <= '0;
            rst_cnt_ff <= `BTRW_RST_CYC;
        end
        else
        begin
            wd_last_ff <= wd_sense;
            if (wd_edge || wd_expire || rst_active)
                wd_cnt_ff <= '0;
            else
                wd_cnt_ff <= wd_cnt_ff + 1;
            if (wd_expire)
                rst_cnt_ff <= `BTRW_RST_CYC;
            else if (rst_active)
                rst_cnt_ff <= rst_cnt_ff - 1;
        end
    end

    // Reset pulse is issued from the watchdog reset counter, stretched to a fixed width
    logic sys_rst_n_ff;
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            sys_rst_n_ff <= 1'b0;
        else
            sys_rst_n_ff <= ~rst_active;
    end
    assign SYS_RESET_N_O = sys_rst_n_ff;
    assign RESET_LED_O = sys_rst_n_ff;

    // RTC time base: everything derives from the 32.768 kHz half period
    logic [`BTRW_CNT_W-1:0] base_div_ff;
    logic base_clk_ff;
    logic [15:0] base_cnt_ff;
    logic irq_n_ff;
    wire logic base_toggle = (base_div_ff == `BTRW_BASE_DIV - 1);
    // 32768/128 = 256 base cycles per tick, i.e. 512 toggles; count rising edges
    wire logic base_rise = base_toggle & ~base_clk_ff;
    wire logic tick = base_rise & (base_cnt_ff == `BTRW_BASE_PER_TICK);

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            base_div_ff <= '0;
            base_clk_ff <= 1'b0;
            base_cnt_ff <= '0;
            irq_n_ff <= 1'b1;
        end
        else
        begin
            base_div_ff <= base_toggle ? '0 : base_div_ff + 1;
            if (base_toggle)
                base_clk_ff <= ~base_clk_ff;
            if (base_rise)
                base_cnt_ff <= tick ? 16'h0000 : base_cnt_ff + 16'h0001;
            irq_n_ff <= ~tick;
        end
    end
    assign REFRESH_CLK_O = base_clk_ff;
    assign RTC_IRQ_N_O = irq_n_ff;

    // Serial port: each access moves one bit, the MSB of the data byte
    logic wr_last_ff, rd_last_ff;
    logic [7:0] led_shift_ff;
    logic [2:0] bit_cnt_ff;
    logic led_ff, rdata_ff;
    wire logic wr_fall = wr_last_ff & ~ser_wr_n;
    wire logic rd_fall = rd_last_ff & ~ser_rd_n;
    wire logic led_wr = wr_fall & ~LED_SEL_N_I;
    wire logic byte_done = led_wr & (bit_cnt_ff == `BTRW_SER_BITS);

    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wr_last_ff <= 1'b1;
            rd_last_ff <= 1'b1;
            led_shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
            led_ff <= 1'b0;
            rdata_ff <= 1'b0;
        end
        else
        begin
            wr_last_ff <= ser_wr_n;
            rd_last_ff <= ser_rd_n;
            if (led_wr)
            begin
                led_shift_ff <= {led_shift_ff[6:0], SERIAL_WDATA_I};
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (byte_done)
                led_ff <= SERIAL_WDATA_I;
            if (rd_fall & ~LED_SEL_N_I)
                rdata_ff <= OPTION_RDATA_I;
        end
    end
    assign PANEL_LED_O = led_ff;
    assign SERIAL_RDATA_O = rdata_ff;
    assign SERIAL_SHIFT_CLOCK_N_O = ser_wr_n & ser_rd_n;
endmodule : btrw_top

// ==== core/btrw_defines.svh ====
// Constants for the bus timeout, reset and watchdog supervisor
`ifndef BTRW_DEFINES_SVH
`define BTRW_DEFINES_SVH
`define BTRW_CLK_HZ 125000000
`define BTRW_WAIT_LIMIT 8'h99
`define BTRW_WAIT_ONE 8'h01
`define BTRW_GRAY_W 4
`define BTRW_HIGH_W 4
`define BTRW_STAGE_W 8
`define BTRW_WD_MS 200
`define BTRW_WD_CYC ((`BTRW_CLK_HZ / 1000) * `BTRW_WD_MS)
`define BTRW_RST_US 10
`define BTRW_RST_CYC ((`BTRW_CLK_HZ / 1000000) * `BTRW_RST_US)
`define BTRW_TICK_HZ 128
`define BTRW_TICK_CYC (`BTRW_CLK_HZ / `BTRW_TICK_HZ)
`define BTRW_BASE_HZ 32768
`define BTRW_BASE_DIV (`BTRW_CLK_HZ / (2 * `BTRW_BASE_HZ))
`define BTRW_BASE_PER_TICK 16'h00FF
`define BTRW_CNT_W 32
`define BTRW_SER_BITS 3'h7
`endif

// ==== core/btrw_pkg.sv ====
// Types for the bus timeout, reset and watchdog supervisor
package btrw_pkg;
    typedef enum logic [1:0] {
        BTRW_IDLE,
        BTRW_COUNT,
        BTRW_DONE
    } btrw_cycle_t;
endpackage : btrw_pkg

// ==== core/btrw_sync_if.sv ====
// Interface carrying raw pins into the synchroniser and clean levels back
interface btrw_sync_if;
    logic [4:0] raw;
    logic [4:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : btrw_sync_if

// ==== core/btrw_sync.sv ====
// Three-stage pin synchroniser, output changes once stages two and three agree
module btrw_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    btrw_sync_if.sync pins
);
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_bit
            logic s1_ff, s2_ff, s3_ff, clean_ff;
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    s1_ff <= 1'b1;
                    s2_ff <= 1'b1;
                    s3_ff <= 1'b1;
                    clean_ff <= 1'b1;
                end
                else
                begin
                    s1_ff <= pins.raw[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff)
                        clean_ff <= s3_ff;
                end
            end
            assign pins.clean[g] = clean_ff;
        end
    endgenerate
endmodule : btrw_sync

// ==== tb/btrw_monitor.sv ====
// Checker on the supervisor pins
module btrw_monitor
    import btrw_pkg::*;
#(
    parameter int WD_CYCLES = 200,
    parameter int TICK_CYCLES = 1
)
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic TRANSFER_START_N_I,
    input wire logic [1:0] SIZE_ACK_N_I,
    input wire logic SERIAL_WR_N_I,
    input wire logic SERIAL_RD_N_I,
    input wire logic TRANSFER_ERROR_N_O,
    input wire logic SYS_RESET_N_O,
    input wire logic RESET_LED_O,
    input wire logic SERIAL_SHIFT_CLOCK_N_O,
    input wire logic RTC_IRQ_N_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] wait_ff;
    logic [3:0] ack_ff;
    logic [10:0] low_ff;
    // Ack age allows for the pin synchroniser lag
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wait_ff <= 9'h000;
            ack_ff <= 4'h0;
            low_ff <= 11'h000;
        end
        else
        begin
            wait_ff <= TRANSFER_START_N_I ? 9'h000 : wait_ff + 9'h001;
            if (TRANSFER_START_N_I)
                ack_ff <= 4'h0;
            else if (ack_ff != 4'hF && (ack_ff != 4'h0 || SIZE_ACK_N_I != 2'h3))
                ack_ff <= ack_ff + 4'h1;
            low_ff <= SYS_RESET_N_O ? 11'h000 : low_ff + 11'h001;
        end
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    sequence err_fell_s;
        $fell(TRANSFER_ERROR_N_O);
    endsequence
    sequence idle_s;
        TRANSFER_START_N_I [*3];
    endsequence
    // Six idle samples cover the synchroniser lag on the strobes
    sequence strobe_idle_s;
        (SERIAL_WR_N_I && SERIAL_RD_N_I) [*6];
    endsequence
    err_pulse_a: assert property (err_fell_s |=> TRANSFER_ERROR_N_O)
        else $error("bus error pulse too long");
    err_limit_a: assert property (err_fell_s |-> wait_ff inside {[150:160]})
        else $error("bus error at wrong wait count");
    ack_stops_a: assert property (ack_ff > 4'h6 |-> TRANSFER_ERROR_N_O)
        else $error("bus error after acknowledge");
    idle_quiet_a: assert property (idle_s |-> TRANSFER_ERROR_N_O)
        else $error("bus error with no cycle");
    led_dark_a: assert property (RESET_LED_O == SYS_RESET_N_O)
        else $error("reset lamp differs from reset");
    rst_len_a: assert property ($rose(SYS_RESET_N_O) |-> low_ff inside {[1245:1255]})
        else $error("reset pulse length wrong");
    rst_hold_a: assert property ($fell(SYS_RESET_N_O) |=> !SYS_RESET_N_O [*8])
        else $error("reset pulse too short");
    irq_pulse_a: assert property ($fell(RTC_IRQ_N_O) |=> RTC_IRQ_N_O)
        else $error("tick pulse too long");
    shift_idle_a: assert property (strobe_idle_s |-> SERIAL_SHIFT_CLOCK_N_O)
        else $error("shift clock low with no strobe");
endmodule : btrw_monitor

bind btrw_top btrw_monitor #(.WD_CYCLES(WD_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_mon (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .TRANSFER_START_N_I(TRANSFER_START_N_I),
    .SIZE_ACK_N_I(SIZE_ACK_N_I), .SERIAL_WR_N_I(SERIAL_WR_N_I), .SERIAL_RD_N_I(SERIAL_RD_N_I),
    .TRANSFER_ERROR_N_O(TRANSFER_ERROR_N_O), .SYS_RESET_N_O(SYS_RESET_N_O),
    .RESET_LED_O(RESET_LED_O), .SERIAL_SHIFT_CLOCK_N_O(SERIAL_SHIFT_CLOCK_N_O),
    .RTC_IRQ_N_O(RTC_IRQ_N_O)
);

// ==== tb/btrw_cpu_model.sv ====
// Processor and peripheral model facing the supervisor
module btrw_cpu_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic wd_en_i,
    input wire logic [1:0] kind_i,
    input wire logic [7:0] dly_i,
    output logic start_n_o,
    output logic ack_n_o,
    output logic [1:0] size_ack_n_o,
    output logic sense_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_ff;
    logic [5:0] wd_ff;
    wire logic hit = go_i && dly_i != 8'h00 && cnt_ff >= dly_i;
    // Acks are held until the cycle ends; the model then drives them high again
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= 8'h00;
            wd_ff <= 6'h00;
            sense_o <= 1'b0;
            start_n_o <= 1'b1;
            ack_n_o <= 1'b1;
            size_ack_n_o <= 2'h3;
        end
        else
        begin
            cnt_ff <= go_i ? cnt_ff + 8'h01 : 8'h00;
            wd_ff <= (wd_ff == 6'h27) ? 6'h00 : wd_ff + 6'h01;
            if (wd_en_i && wd_ff == 6'h27)
                sense_o <= !sense_o;
            start_n_o <= !go_i;
            ack_n_o <= !(hit && kind_i == 2'h2);
            size_ack_n_o <= {!(hit && kind_i == 2'h1), !(hit && kind_i == 2'h0)};
        end
    end
endmodule : btrw_cpu_model

// ==== tb/btrw_tb_top.sv ====
// Self-checking bench for the supervisor
`define CHK(a, e) \
    begin \
        n_compared++; \
        if ((a) !== (e)) \
        begin \
            bad_count++; \
            $display("MISMATCH t=%0t got %b exp %b", $time, (a), (e)); \
        end \
    end
module btrw_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, sel_n, wr_n, rd_n, wd, opt, go, wd_en;
    logic [1:0] kind;
    logic [7:0] dly;
    logic st_n, ta_n, sense, tea_n, srst_n, rled, pled, sck_n, rdat, irq_n, rfc;
    logic [1:0] sz_n;
    int bad_count = 0;
    int n_compared = 0;
    btrw_top #(.WD_CYCLES(200)) uut (.CORE_CLK_I(clk), .RST_I(rst),
        .TRANSFER_START_N_I(st_n), .TRANSFER_ACK_N_I(ta_n), .SIZE_ACK_N_I(sz_n),
        .WATCHDOG_SENSE_I(sense), .LED_SEL_N_I(sel_n), .SERIAL_WR_N_I(wr_n),
        .SERIAL_RD_N_I(rd_n), .SERIAL_WDATA_I(wd), .OPTION_RDATA_I(opt),
        .TRANSFER_ERROR_N_O(tea_n), .SYS_RESET_N_O(srst_n), .RESET_LED_O(rled),
        .PANEL_LED_O(pled), .SERIAL_SHIFT_CLOCK_N_O(sck_n), .SERIAL_RDATA_O(rdat),
        .RTC_IRQ_N_O(irq_n), .REFRESH_CLK_O(rfc));
    btrw_cpu_model cpu (.clk_i(clk), .rst_i(rst), .go_i(go), .wd_en_i(wd_en), .kind_i(kind),
        .dly_i(dly), .start_n_o(st_n), .ack_n_o(ta_n), .size_ack_n_o(sz_n), .sense_o(sense));
    task automatic complete_run;
        $display("bad_count=%0d n_compared=%0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // Output watched by wait_for: 0 bus error, 1 system reset, 2 refresh clock
    function automatic logic pick(input int sel);
        return (sel == 0) ? tea_n : (sel == 1) ? srst_n : rfc;
    endfunction : pick
    // Waits on the falling edge so outputs have settled
    task automatic wait_for(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (pick(sel) !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_for
    task automatic ser(input logic w, input logic s, input logic b);
        @(posedge clk);
        {sel_n, wd, opt} <= {s, b, b};
        if (w)
            wr_n <= 1'b0;
        else
            rd_n <= 1'b0;
        repeat (6) @(negedge clk);
        `CHK(sck_n, 1'b0)
        @(posedge clk);
        {wr_n, rd_n} <= 2'h3;
        repeat (6) @(posedge clk);
    endtask : ser
    task automatic t_reset;
        int n;
        `CHK({tea_n, srst_n, rled}, 3'h4)
        rst <= 1'b0;
        wait_for(1, 1'b1, 2000, n);
        `CHK(n inside {[1245:1255]}, 1'b1)
        `CHK(rled, 1'b1)
        $display("reset test done");
    endtask : t_reset
    task automatic t_timeout;
        int n;
        @(posedge clk);
        {go, dly} <= {1'b1, 8'h00};
        wait_for(0, 1'b0, 400, n);
        `CHK(n inside {[150:160]}, 1'b1)
        @(negedge clk);
        `CHK(tea_n, 1'b1)
        @(posedge clk);
        go <= 1'b0;
        $display("timeout test done");
    endtask : t_timeout
    task automatic t_ack;
        int i, n;
        for (i = 0; i < 3; i++)
        begin
            repeat (4) @(posedge clk);
            {go, kind, dly} <= {1'b1, i[1:0], (i == 1) ? 8'h8C : 8'h0A};
            n = 0;
            repeat (220) @(negedge clk) n += int'(tea_n !== 1'b1);
            `CHK(n == 0, 1'b1)
            @(posedge clk);
            go <= 1'b0;
        end
        $display("acknowledge test done");
    endtask : t_ack
    task automatic t_serial;
        logic [7:0] b;
        int i, k;
        for (k = 0; k < 2; k++)
        begin
            b = k ? 8'h5A : 8'hA5;
            for (i = 7; i >= 0; i--) ser(1'b1, 1'b0, b[i]);
            `CHK(pled, b[0])
        end
        for (i = 0; i < 8; i++) ser(1'b1, 1'b1, 1'b1);
        `CHK(pled, 1'b0)
        for (k = 1; k >= 0; k--)
        begin
            ser(1'b0, 1'b0, k[0]);
            `CHK({rdat, pled}, {k[0], 1'b0})
        end
        $display("serial test done");
    endtask : t_serial
    task automatic t_wdog;
        int n;
        @(posedge clk);
        wd_en <= 1'b0;
        wait_for(1, 1'b0, 600, n);
        `CHK({n inside {[150:215]}, rled}, 2'h2)
        wd_en <= 1'b1;
        wait_for(1, 1'b1, 2000, n);
        `CHK(n inside {[1240:1255]}, 1'b1)
        $display("watchdog test done");
    endtask : t_wdog
    task automatic t_rtc;
        int n;
        wait_for(2, 1'b0, 5000, n);
        wait_for(2, 1'b1, 5000, n);
        wait_for(2, 1'b0, 5000, n);
        // Half period of 32.768 kHz at 8 ns, rounded down by the divider
        `CHK(n inside {[1905:1909]}, 1'b1)
        // First tick is 256 refresh periods away, far beyond this run
        `CHK(irq_n, 1'b1)
        $display("rtc test done");
    endtask : t_rtc
    initial
    begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end
    initial
    begin
        rst = 1'b1;
        {sel_n, wr_n, rd_n} = 3'h7;
        {wd, opt, go} = 3'h0;
        wd_en = 1'b1;
        kind = 2'h0;
        dly = 8'h00;
        repeat (8) @(posedge clk);
        t_reset();
        t_timeout();
        t_ack();
        t_serial();
        t_wdog();
        t_rtc();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        complete_run();
    end
endmodule : btrw_tb_top
